/* File: src/pm_cfg.svh */
`ifndef PM_CFG_SVH
`define PM_CFG_SVH

// Register pointer values
`define OFS_MONITOR_SETTINGS    8'h00
`define OFS_SHUNT_DROP_RESULT   8'h01
`define OFS_RAIL_LEVEL_RESULT   8'h02
`define OFS_LOAD_POWER_RESULT   8'h03
`define OFS_LOAD_CURRENT_RESULT 8'h04
`define OFS_SCALING_FACTOR      8'h05

// Reset values
`define SETTINGS_RST_VAL        16'h4127
`define SCALING_RST_VAL         16'h0000
`define RESULT_RST_VAL          16'h0000

// Settings field layout
`define SETTINGS_SWRST_BIT      15
`define SETTINGS_FIXED_MSB      14
`define SETTINGS_FIXED_LSB      12
`define SETTINGS_FIXED_VAL      3'h4
`define SETTINGS_FREE_MSB       11

// Arithmetic scaling: current divides by 2**11 = 2048, power by 20000
`define CUR_DIV_SHIFT           11
`define CUR_DIV_ROUND           33'h0_0000_07FF
`define PWR_DIV                 32'd20000

// Rail result sign position, forced to zero
`define RAIL_MSB                15

// Default serial bus device address
`define DEV_ADDR_DEFAULT        7'h40

`endif

/* File: src/pm_pkg.sv */
package pm_pkg;

   // Serial register port sequencer
   typedef enum logic [3:0] {
      SB_IDLE,
      SB_ADDR,
      SB_ACK_ADDR,
      SB_PTR,
      SB_ACK_PTR,
      SB_WR_BYTE,
      SB_ACK_WR,
      SB_RD_BYTE,
      SB_RD_ACK
   } serial_state_t;

   // Arithmetic sequencer
   typedef enum logic [1:0] {
      CALC_IDLE,
      CALC_CURRENT,
      CALC_POWER
   } calc_state_t;

endpackage

/* File: src/power_calc_unit.sv */
`timescale 1ns/100ps
`include "pm_cfg.svh"

module power_calc_unit (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        soft_clr,
   input  wire logic [15:0] shunt_word,
   input  wire logic        shunt_stb,
   input  wire logic [15:0] rail_word,
   input  wire logic        rail_stb,
   input  wire logic [15:0] scale,
   input  wire logic        scale_valid,
   output logic      [15:0] shunt_q_ff,
   output logic      [15:0] rail_q_ff,
   output logic      [15:0] current_q_ff,
   output logic      [15:0] power_q_ff
);
   import pm_pkg::*;

   calc_state_t state_ff;
   calc_state_t nxt_state;
   logic [15:0] nxt_current;
   logic [15:0] nxt_power;

   // Signed shunt times unsigned scale, truncated toward zero after /2048
   function automatic logic [15:0] current_of(input logic [15:0] sh, input logic [15:0] cal);
      logic signed [32:0] prod;
      logic signed [32:0] adj;
      prod = $signed(sh) * $signed({1'b0, cal});
      adj  = prod[32] ? prod + $signed(`CUR_DIV_ROUND) : prod;
      current_of = 16'(adj >>> `CUR_DIV_SHIFT);
   endfunction

   // Power uses the current magnitude; the rail word is always positive
   function automatic logic [15:0] power_of(input logic [15:0] cur, input logic [15:0] rail);
      logic [15:0] mag;
      logic [31:0] prod;
      mag  = cur[15] ? 16'(-cur) : cur;
      prod = mag * rail;
      power_of = 16'(prod / `PWR_DIV);
   endfunction

   // Capture averaged words; a new strobe restarts the arithmetic
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shunt_q_ff <= `RESULT_RST_VAL;
         rail_q_ff  <= `RESULT_RST_VAL;
      end else if (soft_clr) begin
         shunt_q_ff <= `RESULT_RST_VAL;
         rail_q_ff  <= `RESULT_RST_VAL;
      end else begin
         if (shunt_stb)
            shunt_q_ff <= shunt_word;
         if (rail_stb)
            rail_q_ff <= {1'b0, rail_word[`RAIL_MSB-1:0]};
      end
   end

   // Sequencer: current first, then power from the fresh current
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         CALC_IDLE:    nxt_state = CALC_IDLE;
         CALC_CURRENT: nxt_state = CALC_POWER;
         CALC_POWER:   nxt_state = CALC_IDLE;
         default:      nxt_state = CALC_IDLE;
      endcase
      if (shunt_stb || rail_stb)
         nxt_state = CALC_CURRENT;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         state_ff <= CALC_IDLE;
      else if (soft_clr)
         state_ff <= CALC_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Without a programmed scale both results stay at zero
   always_comb begin
      nxt_current = current_of(shunt_q_ff, scale);
      nxt_power   = power_of(current_q_ff, rail_q_ff);
      if (!scale_valid) begin
         nxt_current = `RESULT_RST_VAL;
         nxt_power   = `RESULT_RST_VAL;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         current_q_ff <= `RESULT_RST_VAL;
         power_q_ff   <= `RESULT_RST_VAL;
      end else if (soft_clr || !scale_valid) begin
         current_q_ff <= `RESULT_RST_VAL;
         power_q_ff   <= `RESULT_RST_VAL;
      end else begin
         if (state_ff == CALC_CURRENT)
            current_q_ff <= nxt_current;
         if (state_ff == CALC_POWER)
            power_q_ff <= nxt_power;
      end
   end

endmodule // power_calc_unit

/* File: src/power_monitor_calc_engine.sv */
// Operation
// - Current result is shunt result times scaling factor, divided by 2048.
// - Power result is the magnitude of the current result times rail result, divided by 20000.
// - One power step weighs a fixed 25 current steps, with nothing to program.
// - Until the scaling factor is programmed, current and power read zero.
// - Once scaled, current and power refresh on each new averaged measurement.
// - One rail result step is a fixed 1.25 mV regardless of any setting.
// - The top bit of the rail result always reads zero.
// - Shunt word is the difference of the two sense inputs, rail word negative rail to ground.
// - Every result and scaling word is 16 bits moved as two bytes on the serial bus.
`timescale 1ns/100ps
`include "pm_cfg.svh"

module power_monitor_calc_engine #(
   parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic [15:0] shunt_avg,
   input  wire logic        shunt_avg_stb,
   input  wire logic [15:0] rail_avg,
   input  wire logic        rail_avg_stb,
   output logic      [15:0] monitor_settings,
   output logic      [15:0] load_current,
   output logic      [15:0] load_power
);
   import pm_pkg::*;

   // Pin synchronisers; stage 3 is only a delayed copy for edge detection
   logic        scl_s1_ff;
   logic        scl_s2_ff;
   logic        scl_s3_ff;
   logic        sda_s1_ff;
   logic        sda_s2_ff;
   logic        sda_s3_ff;
   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;

   serial_state_t sb_state_ff;
   logic [3:0]  bit_cnt_ff;
   logic [7:0]  rx_ff;
   logic [7:0]  tx_ff;
   logic [7:0]  ptr_ff;
   logic [7:0]  hi_byte_ff;
   logic        byte_sel_ff;
   logic        rw_ff;
   logic        master_nack_ff;
   logic [15:0] rd_word_ff;
   logic        sda_oe_ff;

   logic        wr_stb_ff;
   logic [7:0]  wr_ptr_ff;
   logic [15:0] wr_word_ff;

   logic [15:0] settings_ff;
   logic [15:0] scale_ff;
   logic        scale_valid_ff;
   logic        soft_clr_ff;

   logic [15:0] shunt_q;
   logic [15:0] rail_q;
   logic [15:0] current_q;
   logic [15:0] power_q;
   logic [15:0] rd_mux;

   // Register read decode; unmapped pointers read zero
   function automatic logic [15:0] reg_read(
      input logic [7:0]  ptr,
      input logic [15:0] cfg,
      input logic [15:0] sh,
      input logic [15:0] rl,
      input logic [15:0] pw,
      input logic [15:0] cu,
      input logic [15:0] cal
   );
      case (ptr)
         `OFS_MONITOR_SETTINGS:    reg_read = cfg;
         `OFS_SHUNT_DROP_RESULT:   reg_read = sh;
         `OFS_RAIL_LEVEL_RESULT:   reg_read = rl;
         `OFS_LOAD_POWER_RESULT:   reg_read = pw;
         `OFS_LOAD_CURRENT_RESULT: reg_read = cu;
         `OFS_SCALING_FACTOR:      reg_read = cal;
         default:                  reg_read = 16'h0000;
      endcase
   endfunction

   // Two flops per pin before any logic looks at the levels
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         scl_s3_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_s3_ff <= 1'b1;
      end else begin
         scl_s1_ff <= scl_in;
         scl_s2_ff <= scl_s1_ff;
         scl_s3_ff <= scl_s2_ff;
         sda_s1_ff <= sda_in;
         sda_s2_ff <= sda_s1_ff;
         sda_s3_ff <= sda_s2_ff;
      end
   end

   // Bus events; start and stop only count while the clock line is high
   assign scl_rise  = scl_s2_ff & ~scl_s3_ff;
   assign scl_fall  = ~scl_s2_ff & scl_s3_ff;
   assign bus_start = scl_s2_ff & scl_s3_ff & ~sda_s2_ff & sda_s3_ff;
   assign bus_stop  = scl_s2_ff & scl_s3_ff & sda_s2_ff & ~sda_s3_ff;

   assign rd_mux = reg_read(ptr_ff, settings_ff, shunt_q, rail_q, power_q, current_q, scale_ff);

   // Sample data on the rising clock edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_ff          <= 8'h00;
         master_nack_ff <= 1'b0;
      end else if (scl_rise) begin
         if (sb_state_ff == SB_RD_ACK)
            master_nack_ff <= sda_s2_ff;
         else
            rx_ff <= {rx_ff[6:0], sda_s2_ff};
      end
   end

   // Serial sequencer; the data line only changes after a falling clock edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sb_state_ff <= SB_IDLE;
         bit_cnt_ff  <= 4'h0;
         tx_ff       <= 8'h00;
         ptr_ff      <= 8'h00;
         hi_byte_ff  <= 8'h00;
         byte_sel_ff <= 1'b0;
         rw_ff       <= 1'b0;
         rd_word_ff  <= 16'h0000;
         sda_oe_ff   <= 1'b0;
         wr_stb_ff   <= 1'b0;
         wr_ptr_ff   <= 8'h00;
         wr_word_ff  <= 16'h0000;
      end else begin
         wr_stb_ff <= 1'b0;
         if (bus_start) begin
            sb_state_ff <= SB_ADDR;
            bit_cnt_ff  <= 4'h0;
            sda_oe_ff   <= 1'b0;
         end else if (bus_stop) begin
            sb_state_ff <= SB_IDLE;
            sda_oe_ff   <= 1'b0;
         end else if (scl_rise) begin
            if (sb_state_ff == SB_ADDR || sb_state_ff == SB_PTR ||
                sb_state_ff == SB_WR_BYTE || sb_state_ff == SB_RD_BYTE)
               bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
         end else if (scl_fall) begin
            case (sb_state_ff)
               SB_IDLE: begin
                  sda_oe_ff <= 1'b0;
               end
               SB_ADDR: begin
                  if (bit_cnt_ff == 4'h8) begin
                     if (rx_ff[7:1] == DEV_ADDR) begin
                        sda_oe_ff   <= 1'b1;
                        rw_ff       <= rx_ff[0];
                        sb_state_ff <= SB_ACK_ADDR;
                     end else begin
                        sb_state_ff <= SB_IDLE;
                     end
                  end
               end
               SB_ACK_ADDR: begin
                  bit_cnt_ff  <= 4'h0;
                  byte_sel_ff <= 1'b0;
                  if (rw_ff) begin
                     // Snapshot so both bytes of a word come from one value
                     rd_word_ff  <= rd_mux;
                     sda_oe_ff   <= ~rd_mux[15];
                     tx_ff       <= {rd_mux[14:8], 1'b1};
                     sb_state_ff <= SB_RD_BYTE;
                  end else begin
                     sda_oe_ff   <= 1'b0;
                     sb_state_ff <= SB_PTR;
                  end
               end
               SB_PTR: begin
                  if (bit_cnt_ff == 4'h8) begin
                     ptr_ff      <= rx_ff;
                     sda_oe_ff   <= 1'b1;
                     sb_state_ff <= SB_ACK_PTR;
                  end
               end
               SB_ACK_PTR, SB_ACK_WR: begin
                  sda_oe_ff   <= 1'b0;
                  bit_cnt_ff  <= 4'h0;
                  sb_state_ff <= SB_WR_BYTE;
               end
               SB_WR_BYTE: begin
                  if (bit_cnt_ff == 4'h8) begin
                     sda_oe_ff   <= 1'b1;
                     byte_sel_ff <= ~byte_sel_ff;
                     sb_state_ff <= SB_ACK_WR;
                     // High byte first; the word commits with its low byte
                     if (!byte_sel_ff) begin
                        hi_byte_ff <= rx_ff;
                     end else begin
                        wr_stb_ff  <= 1'b1;
                        wr_ptr_ff  <= ptr_ff;
                        wr_word_ff <= {hi_byte_ff, rx_ff};
                     end
                  end
               end
               SB_RD_BYTE: begin
                  if (bit_cnt_ff == 4'h8) begin
                     sda_oe_ff   <= 1'b0;
                     sb_state_ff <= SB_RD_ACK;
                  end else begin
                     sda_oe_ff <= ~tx_ff[7];
                     tx_ff     <= {tx_ff[6:0], 1'b1};
                  end
               end
               SB_RD_ACK: begin
                  bit_cnt_ff <= 4'h0;
                  if (master_nack_ff) begin
                     sda_oe_ff   <= 1'b0;
                     sb_state_ff <= SB_IDLE;
                  end else begin
                     // Further reads alternate low and high byte of the snapshot
                     byte_sel_ff <= ~byte_sel_ff;
                     if (!byte_sel_ff) begin
                        sda_oe_ff <= ~rd_word_ff[7];
                        tx_ff     <= {rd_word_ff[6:0], 1'b1};
                     end else begin
                        sda_oe_ff <= ~rd_word_ff[15];
                        tx_ff     <= {rd_word_ff[14:8], 1'b1};
                     end
                     sb_state_ff <= SB_RD_BYTE;
                  end
               end
               default: begin
                  sda_oe_ff   <= 1'b0;
                  sb_state_ff <= SB_IDLE;
               end
            endcase
         end
      end
   end

   // Settings word; the top bit requests a full register reset and self-clears
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         settings_ff <= `SETTINGS_RST_VAL;
         soft_clr_ff <= 1'b0;
      end else begin
         soft_clr_ff <= 1'b0;
         if (soft_clr_ff) begin
            settings_ff <= `SETTINGS_RST_VAL;
         end else if (wr_stb_ff && wr_ptr_ff == `OFS_MONITOR_SETTINGS) begin
            if (wr_word_ff[`SETTINGS_SWRST_BIT])
               soft_clr_ff <= 1'b1;
            else
               settings_ff <= {1'b0, `SETTINGS_FIXED_VAL,
                               wr_word_ff[`SETTINGS_FREE_MSB:0]};
         end
      end
   end

   // Scaling factor; any write counts as programmed, so writing zero still yields zero results
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scale_ff       <= `SCALING_RST_VAL;
         scale_valid_ff <= 1'b0;
      end else if (soft_clr_ff) begin
         scale_ff       <= `SCALING_RST_VAL;
         scale_valid_ff <= 1'b0;
      end else if (wr_stb_ff && wr_ptr_ff == `OFS_SCALING_FACTOR) begin
         scale_ff       <= wr_word_ff;
         scale_valid_ff <= 1'b1;
      end
   end

   // Mirror results onto the outputs so every output leaves a flop here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         monitor_settings <= `SETTINGS_RST_VAL;
         load_current     <= `RESULT_RST_VAL;
         load_power       <= `RESULT_RST_VAL;
         sda_oe           <= 1'b0;
         sda_out          <= 1'b0;
      end else begin
         monitor_settings <= settings_ff;
         load_current     <= current_q;
         load_power       <= power_q;
         sda_oe           <= sda_oe_ff;
         sda_out          <= 1'b0;   // Open drain: only ever pulls low
      end
   end

   power_calc_unit u_calc (
      .clk          (clk),
      .rst          (rst),
      .soft_clr     (soft_clr_ff),
      .shunt_word   (shunt_avg),
      .shunt_stb    (shunt_avg_stb),
      .rail_word    (rail_avg),
      .rail_stb     (rail_avg_stb),
      .scale        (scale_ff),
      .scale_valid  (scale_valid_ff),
      .shunt_q_ff   (shunt_q),
      .rail_q_ff    (rail_q),
      .current_q_ff (current_q),
      .power_q_ff   (power_q)
   );

endmodule // power_monitor_calc_engine

/* File: test/power_monitor_calc_engine_assertions.sv */
`timescale 1ns/100ps
`include "pm_cfg.svh"

module power_monitor_calc_engine_assertions (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic [15:0] shunt_avg,
   input wire logic        shunt_avg_stb,
   input wire logic [15:0] rail_avg,
   input wire logic        rail_avg_stb,
   input wire logic [15:0] monitor_settings,
   input wire logic [15:0] load_current,
   input wire logic [15:0] load_power
);
   logic        any_stb;
   logic [15:0] rail_seen_ff;

   // Either strobe restarts the arithmetic
   assign any_stb = shunt_avg_stb | rail_avg_stb;

   // Rail word as the power step sees it; sign bit is dropped on capture
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rail_seen_ff <= 16'h0000;
      end else if (rail_avg_stb) begin
         rail_seen_ff <= {1'b0, rail_avg[14:0]};
      end
   end

   // Wide enough that no product overflows before the divide
   function automatic logic [15:0] pw_of(logic [15:0] c, logic [15:0] r);
      longint m;
      m = longint'($signed(c));
      if (m < 0) begin
         m = -m;
      end
      return 16'(m * longint'(r) / 20000);
   endfunction

   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);

   // A quiet stretch before a strobe, and a strobe followed by full settling
   sequence quiet4;
      !any_stb [*4];
   endsequence
   sequence settled6;
      any_stb ##1 !any_stb [*5];
   endsequence

   a_wire_open_drain: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_power_formula: assert property (
      settled6 |-> load_power == pw_of(load_current, rail_seen_ff))
      else $error("power does not follow current and rail");
   a_results_steady: assert property (
      (!any_stb [*6]) ##0 (monitor_settings != `SETTINGS_RST_VAL)
      |-> $stable(load_current) && $stable(load_power))
      else $error("result moved without a strobe");
   // Output copy of the current moves two edges after the strobe edge
   a_no_early_update: assert property (
      quiet4 ##1 any_stb |-> $stable(load_current) [*3])
      else $error("current changed before its latency");
   a_ack_after_fall: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 3))
      else $error("data pull started outside clock low");
   a_oe_steady_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data pull changed while clock high");
   a_settings_fixed: assert property (monitor_settings[15:12] == 4'h4)
      else $error("settings fixed bits wrong");
   a_reset_state: assert property ($fell(rst) |-> load_current == 16'h0000 && load_power == 16'h0000)
      else $error("results not zero after reset");
endmodule // power_monitor_calc_engine_assertions

/* File: test/pm_i2c_host.sv */
`timescale 1ns/100ps

module pm_i2c_host #(
   parameter logic [6:0] ADDR = 7'h40
) (
   input  wire logic clk,
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_low
);
   // Idle bus: clock high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Eight cycles per phase keeps well clear of the pin synchronisers
   task automatic half();
      repeat (8) @(posedge clk);
   endtask

   // Data changes only mid clock-low; wire sampled late in the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_low <= ~b;
      half();
      scl <= 1'b1;
      half();
      r = sda_wire;
      scl <= 1'b0;
      half();
   endtask

   task automatic start_cond();
      sda_low <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_low <= 1'b1;
      half();
      scl <= 1'b0;
      half();
   endtask

   task automatic stop_cond();
      sda_low <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_low <= 1'b0;
      half();
   endtask

   // Eight bits MSB first, then the acknowledge slot
   task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                          output logic acked);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(last, a);
      acked = ~a;
   endtask

   // Word goes high byte first, low byte last; both are needed to commit
   task automatic write_word(input logic [6:0] a, input logic [7:0] ptr, input logic [15:0] d,
                             output logic ok);
      logic [7:0] q;
      logic k1, k2, k3, k4;
      start_cond();
      byte_io({a, 1'b0}, 1'b1, q, k1);
      byte_io(ptr, 1'b1, q, k2);
      byte_io(d[15:8], 1'b1, q, k3);
      byte_io(d[7:0], 1'b1, q, k4);
      stop_cond();
      ok = k1 & k2 & k3 & k4;
   endtask

   // Pointer set, repeated start, two bytes back with a closing refusal
   task automatic read_word(input logic [7:0] ptr, output logic [15:0] d, output logic ok);
      logic [7:0] q;
      logic k1, k2, k3, kx;
      start_cond();
      byte_io({ADDR, 1'b0}, 1'b1, q, k1);
      byte_io(ptr, 1'b1, q, k2);
      start_cond();
      byte_io({ADDR, 1'b1}, 1'b1, q, k3);
      byte_io(8'hFF, 1'b0, d[15:8], kx);
      byte_io(8'hFF, 1'b1, d[7:0], kx);
      stop_cond();
      ok = k1 & k2 & k3;
   endtask
endmodule // pm_i2c_host

/* File: test/test_power_monitor_calc_engine.sv */
`timescale 1ns/100ps
`include "pm_cfg.svh"

module test_power_monitor_calc_engine;
   logic        clk;
   logic        rst;
   logic        scl;
   logic        host_low;
   wire         sda_wire;
   logic        sda_out;
   logic        sda_oe;
   logic [15:0] shunt_avg;
   logic        shunt_avg_stb;
   logic [15:0] rail_avg;
   logic        rail_avg_stb;
   logic [15:0] monitor_settings;
   logic [15:0] load_current;
   logic [15:0] load_power;
   int          miscompares;
   int          cmp_count;
   logic [15:0] sh_tab [4] = '{16'h3E80, 16'hC180, 16'h0001, 16'hFFFF};
   logic [15:0] rl_tab [4] = '{16'h2560, 16'h2560, 16'hA560, 16'h7FFF};
   logic [15:0] cal_tab [4] = '{16'h0000, 16'h0A00, 16'h07FF, 16'h0801};

   // Open-drain data line with pull-up
   assign sda_wire = ~(host_low | sda_oe);

   power_monitor_calc_engine u_power_monitor_calc_engine (
      .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .shunt_avg(shunt_avg), .shunt_avg_stb(shunt_avg_stb),
      .rail_avg(rail_avg), .rail_avg_stb(rail_avg_stb),
      .monitor_settings(monitor_settings), .load_current(load_current),
      .load_power(load_power));

   pm_i2c_host #(.ADDR(`DEV_ADDR_DEFAULT)) u_pm_i2c_host (
      .clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(host_low));

   // 125 MHz
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check16(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
      logic ok;
      u_pm_i2c_host.write_word(`DEV_ADDR_DEFAULT, ptr, d, ok);
      check16({15'h0000, ok}, 16'h0001);
   endtask

   task automatic rd_chk(input logic [7:0] ptr, input logic [15:0] exp);
      logic [15:0] v;
      logic        ok;
      u_pm_i2c_host.read_word(ptr, v, ok);
      check16({15'h0000, ok}, 16'h0001);
      check16(v, exp);
   endtask

   // Both measurements at once, then room for the fixed result latency
   task automatic strobe(input logic [15:0] sh, input logic [15:0] rl);
      @(posedge clk);
      shunt_avg <= sh;
      rail_avg <= rl;
      shunt_avg_stb <= 1'b1;
      rail_avg_stb <= 1'b1;
      @(posedge clk);
      shunt_avg_stb <= 1'b0;
      rail_avg_stb <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   // Signed product truncated toward zero; low 16 bits kept
   function automatic logic [15:0] exp_cur(logic [15:0] sh, logic [15:0] cal);
      return 16'(longint'($signed(sh)) * longint'(cal) / 2048);
   endfunction

   function automatic logic [15:0] exp_pw(logic [15:0] c, logic [15:0] rl);
      longint m;
      m = longint'($signed(c));
      m = (m < 0) ? -m : m;
      return 16'(m * longint'({1'b0, rl[14:0]}) / 20000);
   endfunction

   initial begin
      logic [15:0] c;
      rst = 1'b1;
      shunt_avg = 16'h0000;
      shunt_avg_stb = 1'b0;
      rail_avg = 16'h0000;
      rail_avg_stb = 1'b0;
      miscompares = 0;
      cmp_count = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      check16(monitor_settings, `SETTINGS_RST_VAL);
      rd_chk(`OFS_SCALING_FACTOR, 16'h0000);
      strobe(sh_tab[0], rl_tab[0]);
      check16(load_current, 16'h0000);
      check16(load_power, 16'h0000);
      rd_chk(`OFS_SHUNT_DROP_RESULT, 16'h3E80);
      rd_chk(`OFS_RAIL_LEVEL_RESULT, 16'h2560);
      $display("test unprogrammed done");
      // 2 mA step rounded up from 55 A / 32767, 1 mOhm shunt
      cal_tab[0] = 16'(int'(0.00512 / (2.0e-3 * 1.0e-3)));
      for (int i = 0; i < 4; i++) begin
         wr(`OFS_SCALING_FACTOR, cal_tab[i]);
         rd_chk(`OFS_SCALING_FACTOR, cal_tab[i]);
         strobe(sh_tab[i], rl_tab[i]);
         c = exp_cur(sh_tab[i], cal_tab[i]);
         check16(load_current, c);
         check16(load_power, exp_pw(c, rl_tab[i]));
         rd_chk(`OFS_LOAD_CURRENT_RESULT, c);
         rd_chk(`OFS_LOAD_POWER_RESULT, exp_pw(c, rl_tab[i]));
         rd_chk(`OFS_RAIL_LEVEL_RESULT, {1'b0, rl_tab[i][14:0]});
      end
      $display("test arithmetic done");
      // Meter reads 40.4 A where 40 A was reported
      c = 16'(int'(2560.0 * 40.4 / 40.0));
      wr(`OFS_SCALING_FACTOR, c);
      strobe(16'h3E80, 16'h2560);
      check16(load_current, exp_cur(16'h3E80, c));
      $display("test recalibration done");
      wr(`OFS_LOAD_CURRENT_RESULT, 16'h1234);
      rd_chk(`OFS_LOAD_CURRENT_RESULT, exp_cur(16'h3E80, c));
      rd_chk(8'h06, 16'h0000);
      wr(`OFS_MONITOR_SETTINGS, 16'h7FFF);
      rd_chk(`OFS_MONITOR_SETTINGS, 16'h4FFF);
      wr(`OFS_MONITOR_SETTINGS, 16'h8000);
      rd_chk(`OFS_MONITOR_SETTINGS, `SETTINGS_RST_VAL);
      rd_chk(`OFS_SCALING_FACTOR, 16'h0000);
      strobe(16'h3E80, 16'h2560);
      check16(load_current, 16'h0000);
      check16(load_power, 16'h0000);
      $display("test registers done");
      u_pm_i2c_host.write_word(7'h41, `OFS_SCALING_FACTOR, 16'h0A00, c[0]);
      check16({15'h0000, c[0]}, 16'h0000);
      rd_chk(`OFS_SCALING_FACTOR, 16'h0000);
      $display("test foreign address done");
      finish_test();
   end
endmodule // test_power_monitor_calc_engine

bind power_monitor_calc_engine power_monitor_calc_engine_assertions
   u_power_monitor_calc_engine_assertions (
      .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .shunt_avg(shunt_avg), .shunt_avg_stb(shunt_avg_stb),
      .rail_avg(rail_avg), .rail_avg_stb(rail_avg_stb),
      .monitor_settings(monitor_settings), .load_current(load_current),
      .load_power(load_power));
